// *** p2m_pkg.sv ***
// Contract
// - Gate and ASCII modes translate by fixed rules; host mode uses operator code and offset.
// - Priority read 0x20 and non-priority read 0x00 become read holding registers, function 3.
// - Priority write 0x1e becomes write multiple registers, function 16.
// - Non-priority write 0x02 with all-ones mask becomes function 16.
// - Non-priority write, count one, partial contiguous mask, becomes masked write, function 22.
// - Anything else is wrapped in function 17 with parameter byte 0x01.
// - Replies to wrapped queries use function 17 with parameter byte 0x02.
// - A function 17 frame with parameters is a wrapped peer command, not genuine.
// - Host, gate and ASCII ports answer wrapped peer messages with a wrapped error.
// - Network, multidrop, Ethernet and token-bus ports forward everything untouched.
// - Coils are read with function 1, written with 5 or 15; first coil 00001.
// - Discrete inputs in the 1XXXXX range are read with function 2.
// - Input registers in the 3XXXXX range are read with function 4.
// - Holding registers read with 3, written with 6 single or 16 multiple.
// - Masked write, function 22, is optional and may be rejected by targets.
// - Function 100 is a random read of holding registers.
// - Native non-priority random-access read is opcode 04.
// - Non-priority write changes only masked bits of the target register.
// - Priority write has no mask and overwrites whole registers.
// - In host mode the register address is remote address plus offset.
package p2m_pkg;

  // ****************************************
  // Modes, kinds, spaces
  // ****************************************
  typedef enum logic [1:0] {MODE_GATE, MODE_ASCII, MODE_HOST, MODE_NET} p2m_mode_t;
  typedef enum logic [2:0] {KIND_READ, KIND_WRITE_REGS, KIND_MASK_WRITE, KIND_ENCAP, KIND_RAW} p2m_kind_t;
  typedef enum logic [2:0] {SPACE_COIL, SPACE_DISC, SPACE_INREG, SPACE_HOLD, SPACE_NONE} p2m_space_t;

  // ****************************************
  // Peer opcodes
  // ****************************************
  localparam logic [7:0] OP_PRI_READ     = 8'h20;
  localparam logic [7:0] OP_NP_READ      = 8'h00;
  localparam logic [7:0] OP_NP_RAND_READ = 8'h04;
  localparam logic [7:0] OP_PRI_WRITE    = 8'h1e;
  localparam logic [7:0] OP_NP_WRITE     = 8'h02;
  localparam logic [7:0] OP_PRI_PRINT    = 8'h22;

  // ****************************************
  // Serial function codes
  // ****************************************
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_DISC  = 8'h02;
  localparam logic [7:0] FC_RD_HOLD  = 8'h03;
  localparam logic [7:0] FC_RD_INREG = 8'h04;
  localparam logic [7:0] FC_WR_COIL  = 8'h05;
  localparam logic [7:0] FC_WR_REG   = 8'h06;
  localparam logic [7:0] FC_WR_COILS = 8'h0f;
  localparam logic [7:0] FC_WR_REGS  = 8'h10;
  localparam logic [7:0] FC_ENCAP    = 8'h11;
  localparam logic [7:0] FC_MASK_WR  = 8'h16;
  localparam logic [7:0] FC_RAND_RD  = 8'h64;

  // ****************************************
  // Wrapping and frame layout
  // ****************************************
  localparam logic [7:0]  ENC_QUERY = 8'h01;
  localparam logic [7:0]  ENC_REPLY = 8'h02;
  localparam logic [7:0]  ERR_CODE  = 8'he0;
  localparam logic [7:0]  ZERO_BYTE = 8'h00;
  localparam logic [7:0]  COUNT_ONE = 8'h01;
  localparam logic [15:0] MASK_ALL  = 16'hffff;
  localparam logic [15:0] BIAS_NONE = 16'h0000;
  localparam logic [2:0]  LEN_READ  = 3'h5;
  localparam logic [2:0]  LEN_WRITE = 3'h6;
  localparam logic [2:0]  LEN_MASK  = 3'h5;
  localparam logic [2:0]  LEN_ENCAP = 3'h3;
  localparam logic [2:0]  LEN_RAW   = 3'h1;
  localparam logic [2:0]  LEN_ERR   = 3'h3;
  localparam logic [2:0]  LEN_NONE  = 3'h0;
  localparam logic [2:0]  LEN_STEP  = 3'h1;

endpackage : p2m_pkg

// *** p2m_op_classify.sv ***
`timescale 1ns/1ps
module p2m_op_classify
  import p2m_pkg::*;
(
  input  wire logic [7:0]  opcode_i,
  input  wire logic [15:0] mask_i,
  input  wire logic [7:0]  count_i,
  input  wire p2m_mode_t   mode_i,
  input  wire logic        is_reply_i,
  output p2m_kind_t        kind_o,
  output logic             is_read_o,
  output logic             rand_read_o
);

  wire        ladder_peer_read  = (opcode_i == OP_PRI_READ);
  wire        np_read           = (opcode_i == OP_NP_READ);
  // Alarm shares the priority write opcode and travels the same way
  wire        ladder_peer_write = (opcode_i == OP_PRI_WRITE);
  wire        np_write          = (opcode_i == OP_NP_WRITE);
  wire [15:0] low_bit           = mask_i & (~mask_i + 16'h0001);
  wire [15:0] filled            = mask_i + low_bit;
  // One run of ones: adding the lowest set bit clears the whole run
  wire        contiguous        = (mask_i != 16'h0000) && ((filled & mask_i) == 16'h0000);
  wire        mask_full         = (mask_i == MASK_ALL);
  wire        mask_part         = !mask_full && contiguous && (count_i == COUNT_ONE);
  wire        any_read          = ladder_peer_read | np_read;
  wire        any_write         = ladder_peer_write | (np_write & mask_full);
  wire        is_net            = (mode_i == MODE_NET);

  assign kind_o      = is_net                 ? KIND_RAW :
                       is_reply_i             ? KIND_ENCAP :
                       any_read               ? KIND_READ :
                       any_write              ? KIND_WRITE_REGS :
                       (np_write & mask_part) ? KIND_MASK_WRITE :
                                                KIND_ENCAP;
  assign is_read_o   = any_read;
  assign rand_read_o = (opcode_i == OP_NP_RAND_READ);

endmodule : p2m_op_classify

// *** p2m_rx_check.sv ***
`timescale 1ns/1ps
module p2m_rx_check
  import p2m_pkg::*;
(
  input  wire logic [7:0] func_i,
  input  wire logic [7:0] param_cnt_i,
  input  wire logic [7:0] param0_i,
  input  wire p2m_mode_t  mode_i,
  output logic            encap_query_o,
  output logic            encap_reply_o,
  output logic            genuine_o,
  output logic            reject_o,
  output p2m_space_t      space_o,
  output logic            is_write_o,
  output logic            optional_o,
  output logic            rand_read_o
);

  wire is_encap_fc = (func_i == FC_ENCAP);
  wire has_params  = (param_cnt_i != ZERO_BYTE);
  wire wrapped     = is_encap_fc && has_params;
  wire serial_mode = (mode_i != MODE_NET);
  wire coil_fc     = (func_i == FC_RD_COILS) || (func_i == FC_WR_COIL) || (func_i == FC_WR_COILS);
  wire hold_fc     = (func_i == FC_RD_HOLD) || (func_i == FC_WR_REG) || (func_i == FC_WR_REGS) ||
                     (func_i == FC_MASK_WR) || (func_i == FC_RAND_RD);

  assign encap_query_o = wrapped && (param0_i == ENC_QUERY);
  assign encap_reply_o = wrapped && (param0_i == ENC_REPLY);
  assign genuine_o     = is_encap_fc && !has_params;
  // Serial translating ports never execute a wrapped command
  assign reject_o      = wrapped && serial_mode;
  assign space_o       = coil_fc                   ? SPACE_COIL :
                         (func_i == FC_RD_DISC)    ? SPACE_DISC :
                         (func_i == FC_RD_INREG)   ? SPACE_INREG :
                         hold_fc                   ? SPACE_HOLD :
                                                     SPACE_NONE;
  assign is_write_o    = (func_i == FC_WR_COIL) || (func_i == FC_WR_REG) || (func_i == FC_WR_COILS) ||
                         (func_i == FC_WR_REGS) || (func_i == FC_MASK_WR);
  assign optional_o    = (func_i == FC_MASK_WR);
  assign rand_read_o   = (func_i == FC_RAND_RD);

endmodule : p2m_rx_check

// *** p2m_translator.sv ***
`timescale 1ns/1ps
module p2m_translator
  import p2m_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire p2m_mode_t   mode_i,
  input  wire logic [15:0] reg_bias_i,
  input  wire logic [7:0]  host_read_fc_i,
  input  wire logic [7:0]  host_write_fc_i,
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  input  wire logic [7:0]  req_opcode_i,
  input  wire logic [15:0] req_addr_i,
  input  wire logic [7:0]  req_count_i,
  input  wire logic [15:0] req_mask_i,
  input  wire logic        req_is_reply_i,
  input  wire logic        in_valid_i,
  output logic             in_ready_o,
  input  wire logic [7:0]  in_data_i,
  input  wire logic        in_last_i,
  output logic             out_valid_o,
  input  wire logic        out_ready_i,
  output logic [7:0]       out_data_o,
  output logic             out_last_o,
  output logic [7:0]       out_func_o,
  output p2m_kind_t        out_kind_o,
  output logic             out_rand_read_o,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_func_i,
  input  wire logic [7:0]  rx_param_cnt_i,
  input  wire logic [7:0]  rx_param0_i,
  output logic             rx_valid_o,
  output logic             rx_encap_query_o,
  output logic             rx_encap_reply_o,
  output logic             rx_genuine_o,
  output logic             rx_reject_o,
  output p2m_space_t       rx_space_o,
  output logic             rx_is_write_o,
  output logic             rx_optional_o,
  output logic             rx_rand_read_o,
  output logic             err_busy_o
);

  // ****************************************
  // Request classification
  // ****************************************
  p2m_kind_t kind_w;
  logic      is_read_w;
  logic      rand_read_w;

  p2m_op_classify u_classify (
    .opcode_i    (req_opcode_i),
    .mask_i      (req_mask_i),
    .count_i     (req_count_i),
    .mode_i      (mode_i),
    .is_reply_i  (req_is_reply_i),
    .kind_o      (kind_w),
    .is_read_o   (is_read_w),
    .rand_read_o (rand_read_w)
  );

  // ****************************************
  // Frame state
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_BODY} p2m_state_t;

  p2m_state_t state_q;
  p2m_state_t state_d;
  logic [63:0] hdr_q;
  logic [63:0] hdr_d;
  logic [2:0]  left_q;
  logic [2:0]  left_d;
  logic        body_q;
  logic        body_d;
  logic        out_valid_q;
  logic        out_valid_d;
  logic [7:0]  out_data_q;
  logic [7:0]  out_data_d;
  logic        out_last_q;
  logic        out_last_d;
  logic [7:0]  out_func_q;
  logic [7:0]  out_func_d;
  p2m_kind_t   out_kind_q;
  p2m_kind_t   out_kind_d;
  logic        rand_q;
  logic        rand_d;
  logic        err_pend_q;
  logic        err_pend_d;

  // ****************************************
  // Address and function selection
  // ****************************************
  wire        host_mode = (mode_i == MODE_HOST);
  // Gate and ASCII always run with a zero offset
  wire [15:0] bias_w    = host_mode ? reg_bias_i : BIAS_NONE;
  wire [15:0] addr_w    = req_addr_i + bias_w;
  wire [7:0]  addr_hi   = addr_w[15:8];
  wire [7:0]  addr_lo   = addr_w[7:0];
  wire [15:0] and_mask  = ~req_mask_i;
  wire [8:0]  byte_cnt9 = {req_count_i, 1'b0};
  // Byte count wraps above 127 registers; the serial side cannot carry more anyway
  wire [7:0]  byte_cnt  = byte_cnt9[7:0];
  wire [7:0]  encap_par = req_is_reply_i ? ENC_REPLY : ENC_QUERY;

  wire [7:0]  fc_read   = host_mode ? host_read_fc_i : FC_RD_HOLD;
  wire [7:0]  fc_write  = host_mode ? host_write_fc_i : FC_WR_REGS;
  wire [7:0]  fc_w      = (kind_w == KIND_READ)       ? fc_read :
                          (kind_w == KIND_WRITE_REGS) ? fc_write :
                          (kind_w == KIND_MASK_WRITE) ? FC_MASK_WR :
                          (kind_w == KIND_ENCAP)      ? FC_ENCAP :
                                                        req_opcode_i;

  // ****************************************
  // Header images, first byte in the top lane
  // ****************************************
  wire [63:0] img_read  = {fc_w, addr_hi, addr_lo, ZERO_BYTE, req_count_i, 24'h000000};
  wire [63:0] img_write = {fc_w, addr_hi, addr_lo, ZERO_BYTE, req_count_i, byte_cnt, 16'h0000};
  // Masked write: the AND mask keeps unselected bits, the payload supplies the OR value
  wire [63:0] img_mask  = {fc_w, addr_hi, addr_lo, and_mask[15:8], and_mask[7:0], 24'h000000};
  // The original opcode rides ahead of the untouched payload
  wire [63:0] img_encap = {FC_ENCAP, encap_par, req_opcode_i, 40'h0000000000};
  wire [63:0] img_raw   = {req_opcode_i, 56'h00000000000000};
  wire [63:0] img_err   = {FC_ENCAP, ENC_REPLY, ERR_CODE, 40'h0000000000};

  wire [63:0] img_w     = (kind_w == KIND_READ)       ? img_read :
                          (kind_w == KIND_WRITE_REGS) ? img_write :
                          (kind_w == KIND_MASK_WRITE) ? img_mask :
                          (kind_w == KIND_ENCAP)      ? img_encap :
                                                        img_raw;
  wire [2:0]  len_w     = (kind_w == KIND_READ)       ? LEN_READ :
                          (kind_w == KIND_WRITE_REGS) ? LEN_WRITE :
                          (kind_w == KIND_MASK_WRITE) ? LEN_MASK :
                          (kind_w == KIND_ENCAP)      ? LEN_ENCAP :
                                                        LEN_RAW;
  // Reads carry no data; a raw read on a transparent port still has its payload
  wire        body_w    = !((kind_w == KIND_READ) && !is_read_w) && (kind_w != KIND_READ);

  // ****************************************
  // Receive-side checks
  // ****************************************
  logic       rx_query_w;
  logic       rx_reply_w;
  logic       rx_genuine_w;
  logic       rx_reject_w;
  p2m_space_t rx_space_w;
  logic       rx_write_w;
  logic       rx_opt_w;
  logic       rx_rand_w;

  p2m_rx_check u_rx_check (
    .func_i        (rx_func_i),
    .param_cnt_i   (rx_param_cnt_i),
    .param0_i      (rx_param0_i),
    .mode_i        (mode_i),
    .encap_query_o (rx_query_w),
    .encap_reply_o (rx_reply_w),
    .genuine_o     (rx_genuine_w),
    .reject_o      (rx_reject_w),
    .space_o       (rx_space_w),
    .is_write_o    (rx_write_w),
    .optional_o    (rx_opt_w),
    .rand_read_o   (rx_rand_w)
  );

  logic       rx_valid_q;
  logic       rx_query_q;
  logic       rx_reply_q;
  logic       rx_genuine_q;
  logic       rx_reject_q;
  p2m_space_t rx_space_q;
  logic       rx_write_q;
  logic       rx_opt_q;
  logic       rx_rand_q;

  // ****************************************
  // Handshake decode
  // ****************************************
  wire out_free   = !out_valid_q || out_ready_i;
  wire idle       = (state_q == ST_IDLE);
  // A pending error answer goes out before any new request is taken
  wire take_err   = idle && err_pend_q;
  wire take_req   = idle && !err_pend_q && req_valid_i;
  wire hdr_step   = (state_q == ST_HDR) && out_free;
  wire hdr_end    = hdr_step && (left_q == LEN_STEP);
  wire body_step  = (state_q == ST_BODY) && out_free && in_valid_i;
  wire body_end   = body_step && in_last_i;
  wire err_event  = rx_valid_i && rx_reject_w;

  assign req_ready_o = idle && !err_pend_q;
  assign in_ready_o  = (state_q == ST_BODY) && out_free;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    state_d     = state_q;
    hdr_d       = hdr_q;
    left_d      = left_q;
    body_d      = body_q;
    out_valid_d = out_free ? 1'b0 : out_valid_q;
    out_data_d  = out_data_q;
    out_last_d  = out_last_q;
    out_func_d  = out_func_q;
    out_kind_d  = out_kind_q;
    rand_d      = rand_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (take_err)
        begin
          state_d    = ST_HDR;
          hdr_d      = img_err;
          left_d     = LEN_ERR;
          body_d     = 1'b0;
          out_func_d = FC_ENCAP;
          out_kind_d = KIND_ENCAP;
          rand_d     = 1'b0;
        end
        else if (take_req)
        begin
          state_d    = ST_HDR;
          hdr_d      = img_w;
          left_d     = len_w;
          body_d     = body_w;
          out_func_d = fc_w;
          out_kind_d = kind_w;
          rand_d     = rand_read_w;
        end
      end
      ST_HDR:
      begin
        if (hdr_step)
        begin
          out_valid_d = 1'b1;
          out_data_d  = hdr_q[63:56];
          out_last_d  = hdr_end && !body_q;
          hdr_d       = {hdr_q[55:0], ZERO_BYTE};
          left_d      = left_q - LEN_STEP;
          if (hdr_end)
          begin
            state_d = body_q ? ST_BODY : ST_IDLE;
          end
        end
      end
      ST_BODY:
      begin
        if (body_step)
        begin
          out_valid_d = 1'b1;
          out_data_d  = in_data_i;
          out_last_d  = in_last_i;
          if (body_end)
          begin
            state_d = ST_IDLE;
          end
        end
      end
    endcase
  end

  // Set wins over clear so an error arriving as the last one is taken is not lost
  assign err_pend_d = err_event ? 1'b1 : (take_err ? 1'b0 : err_pend_q);

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_q     <= ST_IDLE;
      hdr_q       <= 64'h0000000000000000;
      left_q      <= LEN_NONE;
      body_q      <= 1'b0;
      out_valid_q <= 1'b0;
      out_data_q  <= 8'h00;
      out_last_q  <= 1'b0;
      out_func_q  <= 8'h00;
      out_kind_q  <= KIND_RAW;
      rand_q      <= 1'b0;
      err_pend_q  <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      hdr_q       <= hdr_d;
      left_q      <= left_d;
      body_q      <= body_d;
      out_valid_q <= out_valid_d;
      out_data_q  <= out_data_d;
      out_last_q  <= out_last_d;
      out_func_q  <= out_func_d;
      out_kind_q  <= out_kind_d;
      rand_q      <= rand_d;
      err_pend_q  <= err_pend_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rx_valid_q   <= 1'b0;
      rx_query_q   <= 1'b0;
      rx_reply_q   <= 1'b0;
      rx_genuine_q <= 1'b0;
      rx_reject_q  <= 1'b0;
      rx_space_q   <= SPACE_NONE;
      rx_write_q   <= 1'b0;
      rx_opt_q     <= 1'b0;
      rx_rand_q    <= 1'b0;
    end
    else
    begin
      rx_valid_q <= rx_valid_i;
      if (rx_valid_i)
      begin
        rx_query_q   <= rx_query_w;
        rx_reply_q   <= rx_reply_w;
        rx_genuine_q <= rx_genuine_w;
        rx_reject_q  <= rx_reject_w;
        rx_space_q   <= rx_space_w;
        rx_write_q   <= rx_write_w;
        rx_opt_q     <= rx_opt_w;
        rx_rand_q    <= rx_rand_w;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign out_valid_o      = out_valid_q;
  assign out_data_o       = out_data_q;
  assign out_last_o       = out_last_q;
  assign out_func_o       = out_func_q;
  assign out_kind_o       = out_kind_q;
  assign out_rand_read_o  = rand_q;
  assign rx_valid_o       = rx_valid_q;
  assign rx_encap_query_o = rx_query_q;
  assign rx_encap_reply_o = rx_reply_q;
  assign rx_genuine_o     = rx_genuine_q;
  assign rx_reject_o      = rx_reject_q;
  assign rx_space_o       = rx_space_q;
  assign rx_is_write_o    = rx_write_q;
  assign rx_optional_o    = rx_opt_q;
  assign rx_rand_read_o   = rx_rand_q;
  assign err_busy_o       = err_pend_q;

endmodule : p2m_translator

// *** p2m_translator_assertions.sv ***
`timescale 1ns/1ps
module p2m_translator_assertions
  import p2m_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire p2m_mode_t  mode_i,
  input  wire logic       out_valid_o,
  input  wire logic       out_ready_i,
  input  wire logic [7:0] out_data_o,
  input  wire logic       out_last_o,
  input  wire p2m_kind_t  out_kind_o,
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_func_i,
  input  wire logic [7:0] rx_param_cnt_i,
  input  wire logic [7:0] rx_param0_i,
  input  wire logic       rx_valid_o,
  input  wire logic       rx_encap_query_o,
  input  wire logic       rx_genuine_o,
  input  wire p2m_space_t rx_space_o,
  input  wire logic       err_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Function 17 carrying parameters marks a wrapped peer frame
  wire enc_w = rx_valid_i && rx_func_i == FC_ENCAP && rx_param_cnt_i != 8'h00;
  // Marks the frame's opening byte, since a payload gap also makes valid rise
  logic lead_q;
  always_ff @(posedge clk_i)
  begin
    lead_q <= sys_rst_i || (out_valid_o && out_ready_i ? out_last_o : lead_q);
  end
  AST_RX_ANSWER: assert property (rx_valid_i |=> rx_valid_o) else $error("rx answer missing");
  AST_ENC_QUERY: assert property (enc_w && rx_param0_i == ENC_QUERY |=> rx_encap_query_o && !rx_genuine_o)
    else $error("wrapped query not flagged");
  AST_GENUINE: assert property (rx_valid_i && rx_func_i == FC_ENCAP && rx_param_cnt_i == 8'h00 |=> rx_genuine_o)
    else $error("plain function 17 not genuine");
  AST_ERR_SET: assert property (enc_w && mode_i != MODE_NET |=> err_busy_o) else $error("no wrapped error");
  AST_NET_QUIET: assert property (rx_valid_i && mode_i == MODE_NET && !err_busy_o |=> !err_busy_o)
    else $error("network port raised error");
  AST_DISC: assert property (rx_valid_i && rx_func_i == FC_RD_DISC |=> rx_space_o == SPACE_DISC)
    else $error("discrete space wrong");
  AST_INREG: assert property (rx_valid_i && rx_func_i == FC_RD_INREG |=> rx_space_o == SPACE_INREG)
    else $error("input register space wrong");
  AST_HOLD_BYTE: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("byte dropped while stalled");
  AST_ENC_LEAD: assert property (out_valid_o && lead_q && out_kind_o == KIND_ENCAP
    |-> out_data_o == FC_ENCAP) else $error("wrapped lead byte wrong");
  AST_READ_LEAD: assert property ($rose(out_valid_o) && out_kind_o == KIND_READ && mode_i != MODE_HOST
    |-> out_data_o == FC_RD_HOLD) else $error("read lead byte wrong");
  cover property (enc_w);
  cover property ($rose(out_valid_o) && out_kind_o == KIND_MASK_WRITE);
  cover property (out_valid_o && !out_ready_i);
endmodule : p2m_translator_assertions
bind p2m_translator p2m_translator_assertions p2m_translator_assertions_inst (.*);

// *** p2m_serial_slave.sv ***
`timescale 1ns/1ps
module p2m_serial_slave
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       slow_i,
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  input  wire logic       last_i,
  output logic            ready_o,
  output int              frames_o
);
  logic [7:0] got_q[$];
  logic       tog_q;
  // Slow mode takes every other cycle so the sender must hold its bytes
  assign ready_o = !slow_i || tog_q;
  always_ff @(posedge clk_i)
  begin
    tog_q <= sys_rst_i ? 1'b0 : !tog_q;
    if (sys_rst_i)
      frames_o <= 0;
    else if (valid_i && ready_o)
    begin
      got_q.push_back(data_i);
      if (last_i)
        frames_o <= frames_o + 1;
    end
  end
endmodule : p2m_serial_slave

// *** test_p2m_translator.sv ***
`timescale 1ns/1ps
module test_p2m_translator;
  import p2m_pkg::*;
  logic       clk_i, sys_rst_i, req_valid_i, req_is_reply_i, in_valid_i, in_last_i, rx_valid_i, slow;
  logic [15:0] reg_bias_i, req_addr_i, req_mask_i;
  logic [7:0] host_read_fc_i, host_write_fc_i, req_opcode_i, req_count_i, in_data_i, out_data_o, out_func_o;
  logic [7:0] rx_func_i, rx_param_cnt_i, rx_param0_i;
  logic       req_ready_o, in_ready_o, out_valid_o, out_ready_i, out_last_o, out_rand_read_o, rx_valid_o;
  logic       rx_encap_query_o, rx_encap_reply_o, rx_genuine_o, rx_reject_o, rx_is_write_o, rx_optional_o;
  logic       rx_rand_read_o, err_busy_o;
  p2m_mode_t  mode_i;
  p2m_kind_t  out_kind_o;
  p2m_space_t rx_space_o;
  int         errors, n_tests, cyc, frames;
  logic [7:0] exp_q[$];
  p2m_translator p2m_translator_inst (.*);
  p2m_serial_slave p2m_serial_slave_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow), .valid_i(out_valid_o),
    .data_i(out_data_o), .last_i(out_last_o), .ready_o(out_ready_i), .frames_o(frames));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Waits for one more whole frame at the slave, then compares it byte by byte
  task automatic collect(input int f);
    while (frames == f) @(negedge clk_i);
    chk(8'(p2m_serial_slave_inst.got_q.size()), 8'(exp_q.size()));
    foreach (exp_q[k]) chk(p2m_serial_slave_inst.got_q[k], exp_q[k]);
    p2m_serial_slave_inst.got_q.delete();
  endtask : collect
  task automatic send(input logic [7:0] op, input logic [7:0] cnt, input logic [15:0] mk, input logic rep, input int nb);
    int f;
    f = frames;
    @(negedge clk_i);
    {req_opcode_i, req_count_i, req_mask_i, req_is_reply_i, req_valid_i} = {op, cnt, mk, rep, 1'b1};
    while (req_ready_o !== 1'b1) @(negedge clk_i);
    @(negedge clk_i);
    req_valid_i = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      {in_valid_i, in_data_i, in_last_i} = {1'b1, 8'ha0 + i[7:0], i == nb - 1};
      exp_q.push_back(8'ha0 + i[7:0]);
      while (in_ready_o !== 1'b1) @(negedge clk_i);
      @(negedge clk_i);
    end
    in_valid_i = 1'b0;
    collect(f);
  endtask : send
  task automatic rx(input logic [7:0] fc, input logic [7:0] pc, input logic [7:0] p0);
    @(negedge clk_i);
    {rx_valid_i, rx_func_i, rx_param_cnt_i, rx_param0_i} = {1'b1, fc, pc, p0};
    @(negedge clk_i);
    rx_valid_i = 1'b0;
  endtask : rx
  task automatic t_read;
    for (int m = 0; m < 2; m++)
    begin
      mode_i = m ? MODE_ASCII : MODE_GATE;
      exp_q = {FC_RD_HOLD, 8'h12, 8'h34, ZERO_BYTE, 8'h02};
      send(m ? OP_NP_READ : OP_PRI_READ, 8'h02, MASK_ALL, 1'b0, 0);
    end
    mode_i = MODE_HOST;
    exp_q = {FC_RD_INREG, 8'h13, 8'h34, ZERO_BYTE, 8'h02};
    send(OP_PRI_READ, 8'h02, MASK_ALL, 1'b0, 0);
    mode_i = MODE_GATE;
  endtask : t_read
  task automatic t_write;
    slow = 1'b1;
    exp_q = {FC_WR_REGS, 8'h12, 8'h34, ZERO_BYTE, 8'h02, 8'h04};
    send(OP_PRI_WRITE, 8'h02, 16'h0000, 1'b0, 4);
    exp_q = {FC_WR_REGS, 8'h12, 8'h34, ZERO_BYTE, 8'h01, 8'h02};
    send(OP_NP_WRITE, 8'h01, MASK_ALL, 1'b0, 2);
    exp_q = {FC_MASK_WR, 8'h12, 8'h34, 8'hff, 8'h0f};
    send(OP_NP_WRITE, 8'h01, 16'h00f0, 1'b0, 2);
    chk(out_func_o, FC_MASK_WR);
    slow = 1'b0;
  endtask : t_write
  task automatic t_encap;
    exp_q = {FC_ENCAP, ENC_QUERY, OP_PRI_PRINT};
    send(OP_PRI_PRINT, 8'h01, MASK_ALL, 1'b0, 3);
    exp_q = {FC_ENCAP, ENC_QUERY, OP_NP_RAND_READ};
    send(OP_NP_RAND_READ, 8'h01, MASK_ALL, 1'b0, 1);
    chk(8'(out_rand_read_o), 8'h01);
    exp_q = {FC_ENCAP, ENC_REPLY, OP_PRI_READ};
    send(OP_PRI_READ, 8'h01, MASK_ALL, 1'b1, 1);
    mode_i = MODE_NET;
    exp_q = {OP_PRI_WRITE};
    send(OP_PRI_WRITE, 8'h01, MASK_ALL, 1'b0, 2);
    chk(8'(out_kind_o), 8'(KIND_RAW));
    rx(FC_ENCAP, 8'h01, ENC_QUERY);
    chk(8'(err_busy_o), 8'h00);
    mode_i = MODE_GATE;
  endtask : t_encap
  task automatic t_rx;
    logic [7:0] fc[5] = '{FC_RD_COILS, FC_RD_DISC, FC_RD_INREG, FC_RD_HOLD, FC_WR_COILS};
    p2m_space_t sp[5] = '{SPACE_COIL, SPACE_DISC, SPACE_INREG, SPACE_HOLD, SPACE_COIL};
    int f;
    foreach (fc[k])
    begin
      rx(fc[k], 8'h00, 8'h00);
      chk(8'(rx_space_o), 8'(sp[k]));
    end
    rx(FC_MASK_WR, 8'h00, 8'h00);
    chk({5'h00, rx_is_write_o, rx_optional_o, rx_rand_read_o}, 8'h06);
    rx(FC_RAND_RD, 8'h00, 8'h00);
    chk({5'h00, rx_is_write_o, rx_optional_o, rx_rand_read_o}, 8'h01);
    f = frames;
    rx(FC_ENCAP, 8'h01, ENC_QUERY);
    chk({4'h0, rx_encap_reply_o, rx_reject_o, rx_encap_query_o, rx_genuine_o}, 8'h06);
    exp_q = {FC_ENCAP, ENC_REPLY, ERR_CODE};
    collect(f);
  endtask : t_rx
  task final_report;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    if (++cyc > 20000)
    begin
      errors++;
      final_report();
    end
  initial
  begin
    {sys_rst_i, req_valid_i, req_is_reply_i, in_valid_i, in_last_i, rx_valid_i, slow} = 7'h40;
    {mode_i, reg_bias_i, req_addr_i, req_mask_i} = {MODE_GATE, 16'h0100, 16'h1234, 16'h0000};
    {host_read_fc_i, host_write_fc_i, req_opcode_i, req_count_i, in_data_i} = {FC_RD_INREG, FC_WR_REGS, 24'h000000};
    {rx_func_i, rx_param_cnt_i, rx_param0_i} = 24'h000000;
    repeat (12) @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_read();
    t_write();
    t_encap();
    t_rx();
    final_report();
  end
endmodule : test_p2m_translator
